//--- hw/cid_pkg.sv
package cid_pkg;
	// clock and timing base
	localparam int CLK_HZ = 250_000_000;
	localparam int CAPTURE_MS = 25;
	localparam int RELEASE_MS = 30;
	localparam int BAUD = 1200;
	localparam int SCLK_HALF_NS = 500;
	localparam int MODE_HOLD_NS = 1000;

	// derived cycle counts
	localparam int CAPTURE_CYC = (CLK_HZ / 1000) * CAPTURE_MS;
	localparam int RELEASE_CYC = (CLK_HZ / 1000) * RELEASE_MS;
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int MODE_CYC =
		(MODE_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// widths
	localparam int CNT_W = 24;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 4;
	localparam int BYTE_W = 8;
	localparam int FRAME_BITS = 8;
	localparam int REG_COUNT = 16;
	localparam int CHAR_BITS = 10;

	// control register layout
	localparam logic [3:0] MODE_REG_ADDR = 4'h0;
	localparam int SYNC_READ_BIT = 0;
	localparam int ALT_TONE_BIT = 2;
	localparam logic [3:0] REG_RESET = 4'h0;

	typedef logic [CNT_W-1:0] cnt_t;

	// counter reload for a count of cycles
	function automatic cnt_t cycLoad(input int cyc);
		cycLoad = cnt_t'(cyc - 1);
	endfunction
endpackage

//--- hw/cid_link_if.sv
interface cid_link_if;
	logic sclkN; // host shift clock, idle high
	logic modePin; // low: read or framing reset, high: write
	logic serialCmdIn;
	logic serialDataOut;
	logic dataReadyIrqN;

	modport device (
		input sclkN,
		input modePin,
		input serialCmdIn,
		output serialDataOut,
		output dataReadyIrqN
	);

	modport host (
		output sclkN,
		output modePin,
		output serialCmdIn,
		input serialDataOut,
		input dataReadyIrqN
	);
endinterface

//--- hw/write_framer.sv
module write_framer
	import cid_pkg::*;
(
	input wire logic sclkN,
	input wire logic modePin,
	input wire logic serialCmdIn,
	output logic frameDone,
	output logic [cid_pkg::FRAME_BITS-1:0] frameBits
);
	import cid_pkg::*;

	typedef struct packed {
		logic [3:0] count;
		logic [FRAME_BITS-1:0] shift;
		logic done;
	} frame_t;

	frame_t q, d;

	// shift in lsb first, stop after the eighth bit
	always_comb begin
		d = q;
		if (!q.done) begin
			d.shift = {serialCmdIn, q.shift[FRAME_BITS-1:1]};
			d.count = q.count + 4'h1;
			d.done = (q.count == 4'(FRAME_BITS - 1));
		end
	end

	// sample on rising shift clock; mode low clears the framing
	always_ff @(posedge sclkN or negedge modePin) begin
		if (!modePin) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign frameDone = q.done;
	assign frameBits = q.shift;
endmodule

//--- hw/caller_id_device.sv
module caller_id_device
	import cid_pkg::*;
#(
	parameter int CAPTURE_CYC_P = cid_pkg::CAPTURE_CYC,
	parameter int RELEASE_CYC_P = cid_pkg::RELEASE_CYC,
	parameter int BIT_CYC_P = cid_pkg::BIT_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	cid_link_if.device link,
	input wire logic fskRxBit,
	input wire logic callProgressTone,
	output logic toneDetected,
	output logic altToneMode,
	output logic syncReadOption
);
	import cid_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state of the crystal clock domain
	typedef struct packed {
		logic [1:0] fskSync;
		logic [1:0] toneSync;
		logic [1:0] modeSync;
		logic [1:0] doneSync;
		logic [1:0] readSync;
		logic donePrev;
		logic readPrev;
		logic [REG_COUNT-1:0][DATA_W-1:0] regs;
		logic rxBusy;
		cnt_t rxCnt;
		logic [3:0] rxBit;
		logic [BYTE_W-1:0] rxShift;
		logic [BYTE_W-1:0] heldByte;
		logic byteReady;
		cnt_t toneCnt;
		logic toneDet;
		logic txBusy;
		cnt_t txCnt;
		logic [3:0] txBit;
		logic [CHAR_BITS-1:0] txShift;
		logic txSdo;
		logic irqN;
		logic altTone;
		logic syncOpt;
	} core_t;

	// state of the shift clock domain (read side)
	typedef struct packed {
		logic [3:0] idx;
		logic serial_data_out;
		logic done;
	} rd_t;

	core_t q, d;
	rd_t rq, rd;
	logic frameDone;
	logic [FRAME_BITS-1:0] frameBits;

	////////////////////////////////////////////////////////////////////
	// write framing on the shift clock
	write_framer framer (
		.sclkN(link.sclkN),
		.modePin(link.modePin),
		.serialCmdIn(link.serialCmdIn),
		.frameDone(frameDone),
		.frameBits(frameBits)
	);

	////////////////////////////////////////////////////////////////////
	// next state of the crystal clock domain
	always_comb begin
		d = q;
		// two-stage synchronisers, stage 0 read only by stage 1
		d.fskSync = {q.fskSync[0], fskRxBit};
		d.toneSync = {q.toneSync[0], callProgressTone};
		d.modeSync = {q.modeSync[0], link.modePin};
		d.doneSync = {q.doneSync[0], frameDone};
		d.readSync = {q.readSync[0], rq.done};
		d.donePrev = q.doneSync[1];
		d.readPrev = q.readSync[1];

		// commit a finished write frame once
		if (q.doneSync[1] && !q.donePrev) begin
			d.regs[frameBits[ADDR_W-1:0]] =
				frameBits[FRAME_BITS-1:ADDR_W];
		end
		d.altTone = q.regs[MODE_REG_ADDR][ALT_TONE_BIT];
		d.syncOpt = q.regs[MODE_REG_ADDR][SYNC_READ_BIT];

		// start-stop deframer, sampled mid bit
		if (!q.rxBusy) begin
			if (!q.fskSync[1]) begin
				d.rxBusy = 1'b1;
				d.rxCnt = cycLoad(BIT_CYC_P / 2);
				d.rxBit = 4'h0;
			end
		end else if (q.rxCnt != '0) begin
			d.rxCnt = q.rxCnt - cnt_t'(1);
		end else begin
			d.rxCnt = cycLoad(BIT_CYC_P);
			d.rxBit = q.rxBit + 4'h1;
			if (q.rxBit == 4'h0 && q.fskSync[1]) begin
				d.rxBusy = 1'b0; // false start
			end else if (q.rxBit != 4'h0 && q.rxBit <= 4'(BYTE_W)) begin
				d.rxShift = {q.fskSync[1], q.rxShift[BYTE_W-1:1]};
			end else if (q.rxBit == 4'(BYTE_W + 1)) begin
				d.rxBusy = 1'b0;
			end
		end

		// byte taken by the host: sync read done or async sent
		if (q.readSync[1] && !q.readPrev) begin
			d.byteReady = 1'b0;
		end
		if (q.txBusy && q.txCnt == '0 && q.txBit == 4'(CHAR_BITS - 1)) begin
			d.byteReady = 1'b0;
		end
		// a new character wins over the clear
		if (q.rxBusy && q.rxCnt == '0 && q.rxBit == 4'(BYTE_W + 1)
			&& q.fskSync[1]) begin
			d.heldByte = q.rxShift;
			d.byteReady = 1'b1;
		end

		// call progress tone capture and release timing
		if (q.toneSync[1] != q.toneDet) begin
			if (q.toneCnt == cycLoad(q.toneDet ? RELEASE_CYC_P
				: CAPTURE_CYC_P)) begin
				d.toneDet = q.toneSync[1];
				d.toneCnt = '0;
			end else begin
				d.toneCnt = q.toneCnt + cnt_t'(1);
			end
		end else begin
			d.toneCnt = '0;
		end

		// self-timed character output while mode is low
		if (!q.txBusy) begin
			d.txSdo = 1'b1;
			if (q.byteReady && !q.modeSync[1] && !q.syncOpt) begin
				d.txBusy = 1'b1;
				d.txShift = {1'b1, q.heldByte, 1'b0};
				d.txCnt = cycLoad(BIT_CYC_P);
				d.txBit = 4'h0;
				d.txSdo = 1'b0;
			end
		end else if (q.txCnt != '0) begin
			d.txCnt = q.txCnt - cnt_t'(1);
		end else begin
			d.txCnt = cycLoad(BIT_CYC_P);
			d.txShift = {1'b1, q.txShift[CHAR_BITS-1:1]};
			d.txBit = q.txBit + 4'h1;
			d.txSdo = q.txShift[1];
			if (q.txBit == 4'(CHAR_BITS - 1)) begin
				d.txBusy = 1'b0;
				d.txSdo = 1'b1;
			end
		end

		// interrupt low for a held byte or a detected tone
		d.irqN = !(d.byteReady || d.toneDet);
	end

	// register the crystal clock domain
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
			q.fskSync <= 2'h3;
			q.modeSync <= 2'h3;
			// start high so a frame left done does not commit again
			q.doneSync <= 2'h3;
			q.donePrev <= 1'b1;
			q.readSync <= 2'h3;
			q.readPrev <= 1'b1;
			q.rxShift <= 8'h00;
			q.txSdo <= 1'b1;
			q.irqN <= 1'b1;
			q.regs <= {REG_COUNT{REG_RESET}};
		end else if (clkEn) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// synchronous read: next bit at each falling shift clock
	always_comb begin
		rd = rq;
		if (rq.idx < 4'(BYTE_W)) begin
			rd.serial_data_out = q.heldByte[rq.idx[2:0]];
			rd.idx = rq.idx + 4'h1;
			rd.done = (rq.idx == 4'(BYTE_W - 1));
		end
	end

	// mode high holds the read side cleared
	always_ff @(negedge link.sclkN or posedge link.modePin) begin
		if (link.modePin) begin
			rq <= '0;
		end else begin
			rq <= rd;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pins and user outputs
	assign link.serialDataOut = q.syncOpt ? rq.serial_data_out : q.txSdo;
	assign link.dataReadyIrqN = q.irqN;
	assign toneDetected = q.toneDet;
	assign altToneMode = q.altTone;
	assign syncReadOption = q.syncOpt;
endmodule

//--- hw/caller_id_host.sv
module caller_id_host
	import cid_pkg::*;
#(
	parameter int BIT_CYC_P = cid_pkg::BIT_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	cid_link_if.host link,
	input wire logic wrValid,
	input wire logic [cid_pkg::ADDR_W-1:0] wrAddr,
	input wire logic [cid_pkg::DATA_W-1:0] wrData,
	input wire logic rdValid,
	output logic ready,
	output logic [cid_pkg::BYTE_W-1:0] rxByte,
	output logic rxValid,
	output logic irqSeen
);
	import cid_pkg::*;

	typedef enum logic [3:0] {
		IDLE, W_PULSE, W_SETUP, W_LOW, W_HIGH,
		R_SETUP, R_LOW, R_HIGH, R_START, R_BITS, R_END
	} st_t;

	typedef struct packed {
		st_t st;
		cnt_t cnt;
		logic [3:0] bitIdx;
		logic [BYTE_W-1:0] sh;
		logic syncOpt;
		logic modePin;
		logic sclkN;
		logic serial_cmd_in;
		logic [1:0] sdoSync;
		logic [1:0] irqSync;
		logic ready;
		logic [BYTE_W-1:0] rxByte;
		logic rxValid;
		logic irqSeen;
	} host_t;

	host_t q, d;

	// host sequencer
	always_comb begin
		d = q;
		d.sdoSync = {q.sdoSync[0], link.serialDataOut};
		d.irqSync = {q.irqSync[0], link.dataReadyIrqN};
		d.irqSeen = !q.irqSync[1];
		d.rxValid = 1'b0;
		d.cnt = (q.cnt != '0) ? q.cnt - cnt_t'(1) : '0;
		unique case (q.st)
			IDLE: begin
				if (wrValid) begin
					d.st = W_PULSE;
					d.sh = {wrData, wrAddr};
					if (wrAddr == MODE_REG_ADDR) begin
						d.syncOpt = wrData[SYNC_READ_BIT];
					end
					d.modePin = 1'b0;
					d.cnt = cycLoad(MODE_CYC);
					d.ready = 1'b0;
				end else if (rdValid) begin
					d.st = R_SETUP;
					d.modePin = 1'b0;
					d.cnt = cycLoad(MODE_CYC);
					d.ready = 1'b0;
				end
			end
			W_PULSE: if (q.cnt == '0) begin
				d.st = W_SETUP;
				d.modePin = 1'b1;
				d.cnt = cycLoad(MODE_CYC);
				d.bitIdx = 4'h0;
			end
			W_SETUP, W_HIGH: if (q.cnt == '0) begin
				if (q.st == W_HIGH && q.bitIdx == 4'(FRAME_BITS - 1)) begin
					d.st = IDLE;
					d.ready = 1'b1;
				end else begin
					d.st = W_LOW;
					d.sclkN = 1'b0;
					d.serial_cmd_in = q.sh[0];
					d.sh = q.sh >> 1;
					d.bitIdx = (q.st == W_HIGH) ? q.bitIdx + 4'h1 : 4'h0;
					d.cnt = cycLoad(SCLK_HALF_CYC);
				end
			end
			W_LOW: if (q.cnt == '0) begin
				d.st = W_HIGH;
				d.sclkN = 1'b1; // device samples here
				d.cnt = cycLoad(SCLK_HALF_CYC);
			end
			// self-timed read must not wait: the character starts at once
			R_SETUP: if (q.cnt == '0 || !q.syncOpt) begin
				d.bitIdx = 4'h0;
				d.st = q.syncOpt ? R_LOW : R_START;
				d.sclkN = !q.syncOpt;
				d.cnt = cycLoad(SCLK_HALF_CYC);
			end
			R_LOW: if (q.cnt == '0) begin
				d.st = R_HIGH;
				d.sclkN = 1'b1;
				d.sh = {q.sdoSync[1], q.sh[BYTE_W-1:1]};
				d.cnt = cycLoad(SCLK_HALF_CYC);
			end
			R_HIGH: if (q.cnt == '0) begin
				d.bitIdx = q.bitIdx + 4'h1;
				d.st = (q.bitIdx == 4'(BYTE_W - 1)) ? R_END : R_LOW;
				d.sclkN = (q.bitIdx == 4'(BYTE_W - 1));
				d.cnt = cycLoad(SCLK_HALF_CYC);
			end
			R_START: if (!q.sdoSync[1]) begin
				d.st = R_BITS;
				d.cnt = cycLoad(BIT_CYC_P + BIT_CYC_P / 2);
			end
			R_BITS: if (q.cnt == '0) begin
				d.sh = {q.sdoSync[1], q.sh[BYTE_W-1:1]};
				d.bitIdx = q.bitIdx + 4'h1;
				d.cnt = cycLoad(BIT_CYC_P);
				if (q.bitIdx == 4'(BYTE_W - 1)) begin
					d.st = R_END;
					d.cnt = cycLoad(MODE_CYC); // keep mode low a full pulse
				end
			end
			R_END: if (q.cnt == '0) begin
				d.st = IDLE;
				d.modePin = 1'b1;
				d.rxByte = q.sh;
				d.rxValid = 1'b1;
				d.ready = 1'b1;
			end
			default: d.st = IDLE;
		endcase
	end

	// register the host state
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
			q.st <= IDLE;
			q.modePin <= 1'b1;
			q.sclkN <= 1'b1;
			q.sdoSync <= 2'h3;
			q.irqSync <= 2'h3;
			q.ready <= 1'b1;
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign link.modePin = q.modePin;
	assign link.sclkN = q.sclkN;
	assign link.serialCmdIn = q.serial_cmd_in;
	assign ready = q.ready;
	assign rxByte = q.rxByte;
	assign rxValid = q.rxValid;
	assign irqSeen = q.irqSeen;
endmodule

//--- bench/cid_link_properties.sv
module cid_link_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclkN,
	input wire logic modePin,
	input wire logic serialCmdIn,
	input wire logic serialDataOut,
	input wire logic dataReadyIrqN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] lowQ, levQ, ageQ;
	logic [3:0] fallQ;

	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// cycle counters watching the link wires
	always_ff @(posedge mclk) begin
		if (rst) begin
			lowQ <= '0;
			levQ <= '0;
			ageQ <= '0;
			fallQ <= '0;
		end else begin
			lowQ <= modePin ? '0 : lowQ + 32'h1;
			levQ <= $changed(sclkN) ? '0 : levQ + 32'h1;
			ageQ <= $changed(serialCmdIn) ? '0 : ageQ + 32'h1;
			fallQ <= $changed(modePin) ? '0 : fallQ + 4'($fell(sclkN));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link timing and framing
	a_mode_low_width: assert property ($rose(modePin) |-> lowQ >= 249)
		else $error("mode low pulse too short");
	a_mode_sclk_idle: assert property ($changed(modePin) |-> sclkN)
		else $error("mode changed with shift clock low");
	a_mode_steady_clk: assert property (!sclkN |-> $stable(modePin))
		else $error("mode moved during a clock pulse");
	a_cmd_setup_time: assert property ($rose(sclkN) && modePin
		|-> ageQ >= 62)
		else $error("command bit setup too short");
	a_cmd_hold_time: assert property ($rose(sclkN) && modePin
		|=> $stable(serialCmdIn) [*8])
		else $error("command bit hold too short");
	a_sclk_pulse_width: assert property ($changed(sclkN) |-> levQ >= 99)
		else $error("shift clock pulse too short");
	a_sdo_steady_rise: assert property ($rose(sclkN) && !modePin
		|-> $stable(serialDataOut) [*8])
		else $error("read data moved near rising clock");
	a_frame_bit_count: assert property ($changed(modePin)
		|-> fallQ <= 4'h8)
		else $error("more than eight clocks in a frame");

	// main scenarios reached
	c_write_bit: cover property ($rose(sclkN) && modePin);
	c_sync_read_bit: cover property ($rose(sclkN) && !modePin);
	c_async_start: cover property ($fell(serialDataOut) && !modePin && sclkN);
	c_irq_raised: cover property ($fell(dataReadyIrqN));
endmodule

//--- bench/testbench.sv
`define CHK(g, e) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("MISMATCH t=%0t got %h want %h", $time, g, e); \
	end \
end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cid_pkg::*;
	localparam int CAP = 40;
	localparam int REL = 50;
	localparam int BITC = 16;
	typedef struct packed {
		logic [3:0] a;
		logic [3:0] d;
		logic alt;
		logic syn;
		logic [7:0] b;
	} row_t;
	logic mclk, rst, fskRxBit, callProgressTone, toneDetected;
	logic altToneMode, syncReadOption, wrValid, rdValid, ready;
	logic rxValid, irqSeen;
	logic [3:0] wrAddr, wrData;
	logic [7:0] rxByte;
	int fails, check_count;
	// write, expected control bits, byte read back
	row_t rows[4] = '{
		'{4'h0, 4'h4, 1'h1, 1'h0, 8'hA5},
		'{4'h0, 4'h1, 1'h0, 1'h1, 8'h01},
		'{4'h3, 4'hA, 1'h0, 1'h1, 8'h80},
		'{4'h0, 4'h5, 1'h1, 1'h1, 8'h3C}};

	////////////////////////////////////////////////////////////////////////
	// both ends joined on one link
	cid_link_if link();
	caller_id_device #(.CAPTURE_CYC_P(CAP), .RELEASE_CYC_P(REL),
		.BIT_CYC_P(BITC)) i_caller_id_device (.mclk(mclk), .rst(rst),
		.clkEn(1'h1), .link(link), .fskRxBit(fskRxBit),
		.callProgressTone(callProgressTone), .toneDetected(toneDetected),
		.altToneMode(altToneMode), .syncReadOption(syncReadOption));
	caller_id_host #(.BIT_CYC_P(BITC)) i_caller_id_host (.mclk(mclk),
		.rst(rst), .clkEn(1'h1), .link(link), .wrValid(wrValid),
		.wrAddr(wrAddr), .wrData(wrData), .rdValid(rdValid), .ready(ready),
		.rxByte(rxByte), .rxValid(rxValid), .irqSeen(irqSeen));
	cid_link_properties i_cid_link_properties (.mclk(mclk), .rst(rst),
		.sclkN(link.sclkN), .modePin(link.modePin),
		.serialCmdIn(link.serialCmdIn), .serialDataOut(link.serialDataOut),
		.dataReadyIrqN(link.dataReadyIrqN));

	// 250 MHz clock
	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	// bench tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// bounded wait on ready (0) or rxValid (1)
	task automatic waitHi(input logic sel);
		int n;
		n = 0;
		while ((sel ? rxValid : ready) !== 1'h1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		if (n == 20000) begin
			fails++;
			$display("MISMATCH t=%0t wait ran out", $time);
			tally_and_finish();
		end
	endtask

	task automatic doReset();
		rst = 1'h1;
		repeat (4) @(negedge mclk);
		rst = 1'h0;
		@(negedge mclk);
	endtask

	task automatic checkIdle();
		`CHK(link.dataReadyIrqN, 1'h1)
		`CHK(link.serialDataOut, 1'h1)
		`CHK({link.modePin, link.sclkN, ready}, 3'h7)
		`CHK({toneDetected, altToneMode, syncReadOption}, 3'h0)
	endtask

	task automatic hostWrite(input logic [3:0] a, input logic [3:0] d);
		wrAddr = a;
		wrData = d;
		wrValid = 1'h1;
		@(negedge mclk);
		wrValid = 1'h0;
		@(negedge mclk);
		waitHi(1'h0);
		repeat (4) @(negedge mclk);
	endtask

	// start-stop character on the receive stream, lsb first
	task automatic sendChar(input logic [7:0] b, input logic stopBit);
		logic [9:0] f;
		f = {stopBit, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			fskRxBit = f[i];
			repeat (BITC) @(negedge mclk);
		end
		fskRxBit = 1'h1;
		repeat (2 * BITC) @(negedge mclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'h1;
		wrValid = 1'h0;
		rdValid = 1'h0;
		wrAddr = 4'h0;
		wrData = 4'h0;
		fskRxBit = 1'h1;
		callProgressTone = 1'h0;
		fails = 0;
		check_count = 0;
		doReset();
		checkIdle();
		$display("test reset values done");
		// write a register, then move one byte out
		for (int i = 0; i < 4; i++) begin
			hostWrite(rows[i].a, rows[i].d);
			`CHK(altToneMode, rows[i].alt)
			`CHK(syncReadOption, rows[i].syn)
			sendChar(rows[i].b, 1'h1);
			`CHK({link.dataReadyIrqN, irqSeen}, 2'h1)
			rdValid = 1'h1;
			@(negedge mclk);
			rdValid = 1'h0;
			waitHi(1'h1);
			`CHK(rxByte, rows[i].b)
			repeat (10) @(negedge mclk);
			`CHK(link.dataReadyIrqN, 1'h1)
		end
		$display("test write and read rows done");
		// broken stop bit drops the character
		sendChar(8'h5A, 1'h0);
		`CHK(link.dataReadyIrqN, 1'h1)
		$display("test bad stop bit done");
		// tone capture and release times
		callProgressTone = 1'h1;
		repeat (CAP - 5) @(negedge mclk);
		`CHK(toneDetected, 1'h0)
		repeat (12) @(negedge mclk);
		`CHK({toneDetected, link.dataReadyIrqN}, 2'h2)
		callProgressTone = 1'h0;
		repeat (REL - 5) @(negedge mclk);
		`CHK(link.dataReadyIrqN, 1'h0)
		repeat (12) @(negedge mclk);
		`CHK({toneDetected, link.dataReadyIrqN}, 2'h1)
		$display("test tone done");
		// reset in mid-run clears the control register
		hostWrite(4'h0, 4'h5);
		`CHK(altToneMode, 1'h1)
		doReset();
		checkIdle();
		// a frame still done at reset must not be applied again
		repeat (8) @(negedge mclk);
		`CHK({altToneMode, syncReadOption}, 2'h0)
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
